// ---- hdl/freq_unit_conv.sv ----
`timescale 1ns/10ps
module freq_unit_conv
  import opdisp_pkg::*;
#(
  parameter int VAL_W  = 16,
  parameter int POLE_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Request
  input  wire logic              start,
  input  wire logic              rpm_mode,
  input  wire logic [VAL_W-1:0]  value,
  input  wire logic [POLE_W-1:0] poles,
  // Answer
  output logic                   busy,
  output logic                   done,
  output logic      [VAL_W-1:0]  result
);

  localparam int NUM_W = VAL_W + 4;
  localparam int CNT_W = $clog2(NUM_W + 1);
  localparam logic [CNT_W-1:0] STEPS = CNT_W'(NUM_W);

  typedef struct packed {
    logic              busy;
    logic              done;
    logic [CNT_W-1:0]  cnt;
    logic [POLE_W-1:0] rem;
    logic [POLE_W-1:0] div;
    logic [NUM_W-1:0]  quo;
    logic [VAL_W-1:0]  result;
  } conv_st_t;

  conv_st_t st_q;
  conv_st_t st_d;
  logic [POLE_W:0] rem_sh;

  // 0.1 Hz steps to r/min: value * 12 / poles, bit-serial
  always_comb
  begin
    st_d   = st_q;
    rem_sh = {st_q.rem, st_q.quo[NUM_W-1]};
    if (ce)
    begin
      st_d.done = 1'b0;
      if (st_q.busy)
      begin
        st_d.quo = {st_q.quo[NUM_W-2:0], 1'b0};
        st_d.rem = rem_sh[POLE_W-1:0];
        if (rem_sh >= {1'b0, st_q.div})
        begin
          st_d.rem    = POLE_W'(rem_sh - {1'b0, st_q.div});
          st_d.quo[0] = 1'b1;
        end
        st_d.cnt = st_q.cnt - CNT_W'(1);
        if (st_q.cnt == CNT_W'(1))
        begin
          st_d.busy   = 1'b0;
          st_d.done   = 1'b1;
          st_d.result = (st_d.quo[NUM_W-1:VAL_W] != '0) ? '1 : st_d.quo[VAL_W-1:0];
        end
      end
      else if (start)
      begin
        if (!rpm_mode)
        begin
          st_d.result = value;
          st_d.done   = 1'b1;
        end
        else if (poles == '0)
        begin
          st_d.result = '1;
          st_d.done   = 1'b1;
        end
        else
        begin
          st_d.busy = 1'b1;
          st_d.cnt  = STEPS;
          st_d.rem  = '0;
          st_d.div  = poles;
          st_d.quo  = NUM_W'({4'h0, value} * NUM_W'(RPM_FACTOR));
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign busy   = st_q.busy;
  assign done   = st_q.done;
  assign result = st_q.result;

endmodule : freq_unit_conv

// ---- hdl/opdisp_pkg.sv ----
package opdisp_pkg;

  // ==========================================================
  // Bus and register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [3:0] A_ITEM_BASE  = 4'h0;
  localparam logic [3:0] A_PWRON_BASE = 4'h1;
  localparam logic [3:0] A_LINE_STEP  = 4'h2;
  localparam logic [3:0] A_FREQ_UNIT  = 4'h6;
  localparam logic [3:0] A_OPER_CTRL  = 4'h7;
  localparam logic [3:0] A_DISP_BASE  = 4'h8;
  localparam logic [3:0] A_STATUS     = 4'hB;
  localparam logic [3:0] A_CONV_VAL   = 4'hC;

  // ==========================================================
  // Monitor item coding
  typedef struct packed {
    logic [3:0] grp;
    logic [7:0] num;
  } mon_item_t;

  localparam logic [3:0] GRP_STATUS  = 4'h1;
  localparam logic [3:0] GRP_TRACE   = 4'h2;
  localparam logic [3:0] GRP_RECORD  = 4'h3;
  localparam logic [3:0] GRP_LAST    = 4'h6;
  localparam logic [7:0] NUM_FIRST   = 8'h01;
  localparam logic [7:0] NUM_SEL_MIN = 8'h04;
  localparam logic [7:0] NUM_LAST    = 8'h14;
  localparam logic [7:0] NUM_FREQ_CMD = 8'h01;
  localparam logic [7:0] NUM_OUT_FREQ = 8'h02;
  localparam logic [7:0] NUM_CURRENT  = 8'h03;
  localparam logic [7:0] L1_ITEM_RST  = 8'h05;
  localparam logic [7:0] L2_ITEM_RST  = 8'h06;
  localparam logic [7:0] L3_ITEM_RST  = 8'h07;

  // ==========================================================
  // Power-on display codes
  localparam logic [2:0] PON_FREQ_CMD = 3'h1;
  localparam logic [2:0] PON_OUT_FREQ = 3'h2;
  localparam logic [2:0] PON_CURRENT  = 3'h3;
  localparam logic [2:0] PON_SELECT   = 3'h4;
  localparam logic [2:0] L1_PON_RST   = 3'h1;
  localparam logic [2:0] L2_PON_RST   = 3'h1;
  localparam logic [2:0] L3_PON_RST   = 3'h3;

  // ==========================================================
  // Units, control and status bits
  localparam logic UNIT_HZ  = 1'b0;
  localparam logic UNIT_RPM = 1'b1;
  localparam logic [3:0] RPM_FACTOR = 4'hC;

  localparam int CTL_SW_EN   = 0;
  localparam int CTL_STOP_EN = 1;
  localparam int CTL_RUN_SW  = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;

  localparam int ST_LOCAL_BIT = 0;
  localparam int ST_RUN_BIT   = 1;
  localparam int ST_HOLD_BIT  = 2;
  localparam int ST_UNIT_BIT  = 3;

  // ==========================================================
  // Carriers and source state machine
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic switch_btn;
    logic stop_btn;
    logic run_btn;
  } key_in_t;

  typedef enum logic [4:0] {
    SRC_LOCAL_STOP  = 5'b00001,
    SRC_LOCAL_RUN   = 5'b00010,
    SRC_REMOTE_STOP = 5'b00100,
    SRC_REMOTE_RUN  = 5'b01000,
    SRC_REMOTE_HOLD = 5'b10000
  } src_state_t;

endpackage : opdisp_pkg

// ---- hdl/operator_panel.sv ----
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module operator_panel
  import opdisp_pkg::*;
#(
  parameter int POLE_W = 8
) (
  // Clock, reset, enable
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic                    clk_en,
  // Register port
  input  wire opdisp_pkg::bus_req_t    bus_req,
  output logic [opdisp_pkg::DATA_W-1:0] bus_rdata,
  // Keypad and terminal pins
  input  wire opdisp_pkg::key_in_t     keys,
  input  wire logic                    ext_run,
  // Drive context
  input  wire logic                    vector_mode,
  input  wire logic [POLE_W-1:0]       pole_count,
  // Monitor value stream
  input  wire logic [15:0]             mon_value,
  input  wire logic                    mon_valid,
  input  wire logic                    mon_is_freq,
  output logic                         mon_ready,
  // Display outputs
  output opdisp_pkg::mon_item_t        disp_line1,
  output opdisp_pkg::mon_item_t        disp_line2,
  output opdisp_pkg::mon_item_t        disp_line3,
  output logic                         disp_unit_rpm,
  output logic [15:0]                  disp_value,
  output logic                         disp_value_valid,
  // Run command
  output logic                         run_cmd,
  output logic                         local_mode
);

  // ==========================================================
  // Helper functions

  // Legal item: status group from floor, groups up to last, no fault groups
  function automatic logic item_ok(input mon_item_t it, input logic [7:0] floor_num);
    logic ok;
    ok = 1'b1;
    if (it.grp < GRP_STATUS || it.grp > GRP_LAST)
      ok = 1'b0;
    if (it.grp == GRP_TRACE || it.grp == GRP_RECORD)
      ok = 1'b0;
    if (it.grp == GRP_STATUS && it.num < floor_num)
      ok = 1'b0;
    if (it.num < NUM_FIRST || it.num > NUM_LAST)
      ok = 1'b0;
    return ok;
  endfunction : item_ok

  // Power-on code to the item that the line starts with
  function automatic mon_item_t pon_item(input logic [2:0] code, input mon_item_t sel);
    mon_item_t it;
    it.grp = GRP_STATUS;
    case (code)
      PON_FREQ_CMD: it.num = NUM_FREQ_CMD;
      PON_OUT_FREQ: it.num = NUM_OUT_FREQ;
      PON_CURRENT:  it.num = NUM_CURRENT;
      default:      it = sel;
    endcase
    return it;
  endfunction : pon_item

  function automatic logic pon_ok(input logic [2:0] code);
    return (code >= PON_FREQ_CMD) && (code <= PON_SELECT);
  endfunction : pon_ok

  // ==========================================================
  // Reset release

  logic [1:0] rst_pipe_q;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_pipe_q <= 2'h0;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end

  assign rst_n = rst_pipe_q[1];

  // ==========================================================
  // Pin synchronisers and unit converter

  key_in_t keys_s;
  logic    ext_run_s;
  logic    conv_busy;
  logic    conv_start;

  pin_sync #(
    .W (4)
  ) u_pin_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .ce    (clk_en),
    .d     ({keys, ext_run}),
    .q     ({keys_s, ext_run_s})
  );

  freq_unit_conv #(
    .VAL_W  (16),
    .POLE_W (POLE_W)
  ) u_conv (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .ce       (clk_en),
    .start    (conv_start),
    .rpm_mode (disp_unit_rpm & mon_is_freq),
    .value    (mon_value),
    .poles    (pole_count),
    .busy     (conv_busy),
    .done     (disp_value_valid),
    .result   (disp_value)
  );

  // Every frequency-type item goes through the selected unit
  assign mon_ready  = ~conv_busy;
  assign conv_start = clk_en & mon_valid & ~conv_busy;

  // ==========================================================
  // State

  typedef struct packed {
    mon_item_t [2:0]        sel;
    logic [2:0][2:0]        pon;
    mon_item_t [2:0]        disp;
    logic                   unit;
    logic [2:0]             ctrl;
    logic                   init;
    src_state_t             src;
    key_in_t                keys_prev;
    logic [DATA_W-1:0]      rdata;
  } panel_st_t;

  localparam panel_st_t ST_RST = '{
    sel:       '{'{GRP_STATUS, L3_ITEM_RST}, '{GRP_STATUS, L2_ITEM_RST},
                 '{GRP_STATUS, L1_ITEM_RST}},
    pon:       '{L3_PON_RST, L2_PON_RST, L1_PON_RST},
    disp:      '0,
    unit:      UNIT_HZ,
    ctrl:      CTRL_RST,
    init:      1'b0,
    src:       SRC_LOCAL_STOP,
    keys_prev: '0,
    rdata:     '0
  };

  panel_st_t st_q;
  panel_st_t st_d;

  logic sw_rise;
  logic stop_rise;
  logic run_rise;
  logic sw_en;
  logic stop_en;
  logic run_on_sw;
  logic [3:0] a_item;
  logic [3:0] a_pon;
  logic [3:0] a_disp;

  assign sw_rise   = keys_s.switch_btn & ~st_q.keys_prev.switch_btn;
  assign stop_rise = keys_s.stop_btn & ~st_q.keys_prev.stop_btn;
  assign run_rise  = keys_s.run_btn & ~st_q.keys_prev.run_btn;
  assign sw_en     = st_q.ctrl[CTL_SW_EN];
  assign stop_en   = st_q.ctrl[CTL_STOP_EN];
  assign run_on_sw = st_q.ctrl[CTL_RUN_SW];

  // ==========================================================
  // Next state

  always_comb
  begin
    st_d   = st_q;
    a_item = '0;
    a_pon  = '0;
    a_disp = '0;
    if (clk_en)
    begin
      st_d.rdata     = '0;
      st_d.keys_prev = keys_s;

      // One-time power-on sampling of the display lines
      if (!st_q.init)
      begin
        st_d.init = 1'b1;
        st_d.unit = vector_mode ? UNIT_RPM : UNIT_HZ;
        st_d.disp[0] = pon_item(st_q.pon[0], st_q.sel[0]);
        st_d.disp[1] = pon_item(st_q.pon[1], st_q.sel[1]);
        st_d.disp[2] = pon_item(st_q.pon[2], st_q.sel[2]);
      end

      // Register writes, illegal values are dropped
      if (bus_req.wr)
      begin
        for (int i = 0; i < 3; i++)
        begin
          a_item = 4'(A_ITEM_BASE + A_LINE_STEP * 4'(i));
          a_pon  = 4'(A_PWRON_BASE + A_LINE_STEP * 4'(i));
          a_disp = 4'(A_DISP_BASE + 4'(i));
          if (bus_req.addr == a_item &&
              item_ok(mon_item_t'(bus_req.wdata[11:0]), NUM_SEL_MIN))
            st_d.sel[i] = mon_item_t'(bus_req.wdata[11:0]);
          if (bus_req.addr == a_pon && pon_ok(bus_req.wdata[2:0]))
            st_d.pon[i] = bus_req.wdata[2:0];
          if (bus_req.addr == a_disp &&
              item_ok(mon_item_t'(bus_req.wdata[11:0]), NUM_FIRST))
            st_d.disp[i] = mon_item_t'(bus_req.wdata[11:0]);
        end
        if (bus_req.addr == A_FREQ_UNIT)
          st_d.unit = bus_req.wdata[0];
        if (bus_req.addr == A_OPER_CTRL)
          st_d.ctrl = bus_req.wdata[2:0];
      end

      // Register reads, data in the following cycle only
      if (bus_req.rd)
      begin
        case (bus_req.addr)
          A_FREQ_UNIT: st_d.rdata = DATA_W'(st_q.unit);
          A_OPER_CTRL: st_d.rdata = DATA_W'(st_q.ctrl);
          A_STATUS:
          begin
            st_d.rdata[ST_LOCAL_BIT] = local_mode;
            st_d.rdata[ST_RUN_BIT]   = run_cmd;
            st_d.rdata[ST_HOLD_BIT]  = (st_q.src == SRC_REMOTE_HOLD);
            st_d.rdata[ST_UNIT_BIT]  = st_q.unit;
          end
          A_CONV_VAL:  st_d.rdata = disp_value;
          default:
          begin
            for (int i = 0; i < 3; i++)
            begin
              if (bus_req.addr == 4'(A_ITEM_BASE + A_LINE_STEP * 4'(i)))
                st_d.rdata = DATA_W'(st_q.sel[i]);
              if (bus_req.addr == 4'(A_PWRON_BASE + A_LINE_STEP * 4'(i)))
                st_d.rdata = DATA_W'(st_q.pon[i]);
              if (bus_req.addr == 4'(A_DISP_BASE + 4'(i)))
                st_d.rdata = DATA_W'(st_q.disp[i]);
            end
          end
        endcase
      end

      // Run command source
      case (st_q.src)
        SRC_LOCAL_STOP:
        begin
          if (run_rise)
            st_d.src = SRC_LOCAL_RUN;
          else if (sw_rise && sw_en && !keys_s.run_btn)
          begin
            if (ext_run_s && run_on_sw)
              st_d.src = SRC_REMOTE_RUN;
            else if (ext_run_s)
              st_d.src = SRC_REMOTE_HOLD;
            else
              st_d.src = SRC_REMOTE_STOP;
          end
        end
        SRC_LOCAL_RUN:
        begin
          if (stop_rise)
            st_d.src = SRC_LOCAL_STOP;
        end
        SRC_REMOTE_STOP:
        begin
          if (ext_run_s)
            st_d.src = SRC_REMOTE_RUN;
          else if (sw_rise && sw_en)
            st_d.src = SRC_LOCAL_STOP;
        end
        SRC_REMOTE_RUN:
        begin
          if (stop_rise && stop_en)
            st_d.src = SRC_REMOTE_HOLD;
          else if (!ext_run_s)
            st_d.src = SRC_REMOTE_STOP;
        end
        SRC_REMOTE_HOLD:
        begin
          // Run must drop before a new run counts; no switching meanwhile
          if (!ext_run_s)
            st_d.src = SRC_REMOTE_STOP;
        end
        default: st_d.src = SRC_LOCAL_STOP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Outputs

  assign bus_rdata     = st_q.rdata;
  assign disp_line1    = st_q.disp[0];
  assign disp_line2    = st_q.disp[1];
  assign disp_line3    = st_q.disp[2];
  assign disp_unit_rpm = st_q.unit;
  assign run_cmd       = (st_q.src == SRC_LOCAL_RUN) || (st_q.src == SRC_REMOTE_RUN);
  assign local_mode    = (st_q.src == SRC_LOCAL_STOP) || (st_q.src == SRC_LOCAL_RUN);

endmodule : operator_panel

// ---- hdl/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st_q;
  sync_st_t st_d;

  // Two-stage shift, only the second stage leaves
  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule : pin_sync

// ---- test/keypad_term_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Keypad buttons and external run terminal
module keypad_term_model
  import opdisp_pkg::*;
(
  input  wire logic          sys_clk,
  output opdisp_pkg::key_in_t keys,
  output logic               ext_run,
  output logic [7:0]         pole_count
);
  // Released buttons, no run level, four poles
  initial
  begin
    keys       = '0;
    ext_run    = 1'b0;
    pole_count = 8'h04;
  end

  // Hold one button for six cycles, then let the panel act
  task automatic press(input int k);
    @(posedge sys_clk);
    keys[k] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : press

  // Run terminal level, then settle time
  task automatic set_ext(input logic v);
    @(posedge sys_clk);
    ext_run <= v;
    repeat (8) @(posedge sys_clk);
  endtask : set_ext

  // Restart after a stop: remove the run level, apply it again
  task automatic rerun();
    set_ext(1'b0);
    set_ext(1'b1);
  endtask : rerun

  // Motor pole count for the speed conversion
  task automatic set_poles(input logic [7:0] p);
    @(posedge sys_clk);
    pole_count <= p;
  endtask : set_poles
endmodule : keypad_term_model

// ---- test/operator_panel_props.sv ----
`timescale 1ns/10ps
// ==========================================================
// Port checks of the operator panel
module operator_panel_props
  import opdisp_pkg::*;
#(
  parameter int POLE_W = 8
) (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  input wire logic                  clk_en,
  // Panel inputs
  input wire opdisp_pkg::bus_req_t  bus_req,
  input wire opdisp_pkg::key_in_t   keys,
  input wire logic                  ext_run,
  input wire logic                  vector_mode,
  input wire logic [POLE_W-1:0]     pole_count,
  input wire logic [15:0]           mon_value,
  input wire logic                  mon_valid,
  input wire logic                  mon_is_freq,
  // Panel outputs
  input wire logic                  mon_ready,
  input wire opdisp_pkg::mon_item_t disp_line1,
  input wire opdisp_pkg::mon_item_t disp_line2,
  input wire opdisp_pkg::mon_item_t disp_line3,
  input wire logic                  disp_unit_rpm,
  input wire logic [15:0]           disp_value,
  input wire logic                  disp_value_valid,
  input wire logic                  run_cmd,
  input wire logic                  local_mode
);
  logic [2:0] ctrl_q;
  logic [2:0] ext_cnt_q;
  logic [3:0] rcnt_q;
  logic       take;
  logic       rpm_take;

  // Control bit shadow, age of the run level, cycles since reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q    <= CTRL_RST;
      ext_cnt_q <= 3'h0;
      rcnt_q    <= 4'h0;
    end
    else
    begin
      if (clk_en && bus_req.wr && bus_req.addr == A_OPER_CTRL)
        ctrl_q <= bus_req.wdata[2:0];
      ext_cnt_q <= !ext_run ? 3'h0 : (ext_cnt_q == 3'h7 ? 3'h7 : ext_cnt_q + 3'h1);
      rcnt_q    <= (rcnt_q == 4'hF) ? 4'hF : rcnt_q + 4'h1;
    end
  end

  // Converter request taken
  assign take     = mon_valid && mon_ready && clk_en;
  assign rpm_take = take && disp_unit_rpm && mon_is_freq && (pole_count != '0);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Assertions
  AST_PON_LINES: assert property (rcnt_q == 4'h8 |->
    disp_line1 == 12'h101 && disp_line2 == 12'h101 && disp_line3 == 12'h103)
    else $error("Power-on display items wrong");
  AST_UNIT_DEFAULT: assert property (rcnt_q == 4'h8 |-> disp_unit_rpm == vector_mode)
    else $error("Unit default wrong");
  AST_HZ_PASS: assert property (take && !(disp_unit_rpm && mon_is_freq) |=>
    disp_value_valid && disp_value == $past(mon_value)) else $error("Direct value wrong");
  AST_RPM_BUSY: assert property (rpm_take |=> !mon_ready [*8])
    else $error("Converter took a value while busy");
  AST_RPM_DONE: assert property (rpm_take |-> ##21 disp_value_valid)
    else $error("Speed result late");
  AST_SW_STOPPED: assert property ($changed(local_mode) |-> !$past(run_cmd))
    else $error("Source changed while running");
  AST_SW_GATED: assert property ($changed(local_mode) |-> $past(ctrl_q[CTL_SW_EN]))
    else $error("Source changed while switching disabled");
  AST_L2R_NO_START: assert property ($fell(local_mode) && !ctrl_q[CTL_RUN_SW] |-> !run_cmd)
    else $error("Drive started on switch");
  AST_L2R_START: assert property ($fell(local_mode) && ctrl_q[CTL_RUN_SW] &&
    ext_cnt_q == 3'h7 |-> run_cmd) else $error("Drive not started on switch");
  AST_STOP_HOLD: assert property (!local_mode && !run_cmd && ext_cnt_q == 3'h7 |=> !run_cmd)
    else $error("Restart without new run level");
  AST_STOP_MASKED: assert property (!local_mode && run_cmd && !ctrl_q[CTL_STOP_EN] &&
    ext_cnt_q == 3'h7 |=> run_cmd) else $error("Masked stop key acted");
  AST_LOCAL_RUN: assert property (local_mode && $rose(run_cmd) |-> $past(keys.run_btn, 3))
    else $error("Local run without keypad run");

  // Main scenarios reached
  COV_RPM: cover property (rpm_take);
  COV_L2R_RUN: cover property ($fell(local_mode) && run_cmd);
  COV_HOLD: cover property (!local_mode && !run_cmd && ext_cnt_q == 3'h7);
endmodule : operator_panel_props

bind operator_panel operator_panel_props #(.POLE_W(POLE_W)) i_operator_panel_props (
  .sys_clk, .arst_n, .clk_en, .bus_req, .keys, .ext_run, .vector_mode, .pole_count,
  .mon_value, .mon_valid, .mon_is_freq, .mon_ready, .disp_line1, .disp_line2, .disp_line3,
  .disp_unit_rpm, .disp_value, .disp_value_valid, .run_cmd, .local_mode);

// ---- test/operator_panel_test.sv ----
`timescale 1ns/10ps
module operator_panel_test;
  import opdisp_pkg::*;
  localparam int K_RUN  = 0;
  localparam int K_STOP = 1;
  localparam int K_SW   = 2;
  localparam logic [15:0] RST_TAB [8] = '{16'h0105, 16'h0001, 16'h0106, 16'h0001,
                                          16'h0107, 16'h0003, 16'h0000, 16'h0003};
  localparam logic [15:0] BAD_TAB [4] = '{16'h0205, 16'h0314, 16'h0103, 16'h0115};
  logic        sys_clk     = 1'b0;
  logic        arst_n      = 1'b0;
  logic        clk_en;
  bus_req_t    bus_req     = '0;
  logic        vector_mode;
  logic [15:0] mon_value;
  logic        mon_valid   = 1'b0;
  logic        mon_is_freq;
  logic [31:0] seed        = 32'h0000F9C5;
  int          mismatches  = 0;
  int          n_compared  = 0;
  key_in_t     keys;
  logic        ext_run;
  logic [7:0]  pole_count;
  logic [15:0] bus_rdata;
  logic [15:0] disp_value;
  mon_item_t   disp_line1;
  mon_item_t   disp_line2;
  mon_item_t   disp_line3;
  logic        disp_unit_rpm;
  logic        disp_value_valid;
  logic        mon_ready;
  logic        run_cmd;
  logic        local_mode;

  // Clock
  always #10 sys_clk = ~sys_clk;

  keypad_term_model i_keypad_term_model (.sys_clk, .keys, .ext_run, .pole_count);
  operator_panel #(.POLE_W(8)) i_operator_panel (.sys_clk, .arst_n, .clk_en, .bus_req,
    .bus_rdata, .keys, .ext_run, .vector_mode, .pole_count, .mon_value, .mon_valid,
    .mon_is_freq, .mon_ready, .disp_line1, .disp_line2, .disp_line3, .disp_unit_rpm,
    .disp_value, .disp_value_valid, .run_cmd, .local_mode);

  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic st(input logic l, input logic r);
    #1;
    chk("local_mode", {15'h0, local_mode}, {15'h0, l});
    chk("run_cmd", {15'h0, run_cmd}, {15'h0, r});
  endtask : st

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [15:0] exp_val(logic [15:0] v, logic f, logic rpm, logic [7:0] p);
    logic [31:0] r;
    if (!(f && rpm))
      return v;
    if (p == 8'h00)
      return 16'hFFFF;
    r = ({16'h0000, v} * {28'h0000000, RPM_FACTOR}) / {24'h000000, p};
    return (r > 32'h0000FFFF) ? 16'hFFFF : r[15:0];
  endfunction : exp_val

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rchk(input string n, input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(n, bus_rdata, exp);
  endtask : rchk

  // One monitor value through the converter
  task automatic mon(input logic [15:0] v, input logic f, input logic rpm);
    int n;
    @(posedge sys_clk);
    mon_value   <= v;
    mon_is_freq <= f;
    mon_valid   <= 1'b1;
    @(posedge sys_clk);
    mon_valid <= 1'b0;
    #1;
    for (n = 0; n < 40 && disp_value_valid !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      #1;
    end
    chk("disp_value", disp_value, exp_val(v, f, rpm, pole_count));
  endtask : mon

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // Watchdog
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] r;
    int          i;
    clk_en <= 1'b1;
    vector_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("disp_line1", {4'h0, disp_line1}, 16'h0101);
    chk("disp_line2", {4'h0, disp_line2}, 16'h0101);
    chk("disp_line3", {4'h0, disp_line3}, 16'h0103);
    chk("unit", {15'h0, disp_unit_rpm}, 16'h0000);
    for (i = 0; i < 8; i++)
      rchk("reset value", 4'(i), RST_TAB[i]);
    rchk("unmapped", 4'hD, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      wr(A_ITEM_BASE, BAD_TAB[i]);
      rchk("line1_item_select", A_ITEM_BASE, 16'h0105);
    end
    wr(4'h2, 16'h0614);
    rchk("line2_item_select", 4'h2, 16'h0614);
    wr(4'h4, 16'h0104);
    rchk("line3_item_select", 4'h4, 16'h0104);
    wr(A_DISP_BASE, 16'h0302);
    #1;
    chk("disp_line1", {4'h0, disp_line1}, 16'h0101);
    wr(A_DISP_BASE, 16'h0102);
    #1;
    chk("disp_line1", {4'h0, disp_line1}, 16'h0102);
    for (i = 0; i < 6; i++)
    begin
      r = xs();
      mon(r[15:0], r[16], 1'b0);
    end
    wr(A_FREQ_UNIT, 16'h0001);
    #1;
    chk("unit", {15'h0, disp_unit_rpm}, 16'h0001);
    mon(16'h0004, 1'b1, 1'b1);
    for (i = 0; i < 5; i++)
    begin
      r = xs();
      i_keypad_term_model.set_poles(r[7:0] | 8'h01);
      mon(r[23:8], r[24], 1'b1);
    end
    i_keypad_term_model.set_poles(8'h00);
    mon(16'h1234, 1'b1, 1'b1);
    i_keypad_term_model.set_poles(8'h04);
    wr(A_FREQ_UNIT, 16'h0000);
    // Run source switching
    i_keypad_term_model.press(K_SW);
    st(1'b0, 1'b0);
    i_keypad_term_model.set_ext(1'b1);
    st(1'b0, 1'b1);
    i_keypad_term_model.press(K_SW);
    st(1'b0, 1'b1);
    i_keypad_term_model.press(K_STOP);
    st(1'b0, 1'b0);
    repeat (10) @(posedge sys_clk);
    st(1'b0, 1'b0);
    i_keypad_term_model.rerun();
    st(1'b0, 1'b1);
    wr(A_OPER_CTRL, 16'h0001);
    i_keypad_term_model.press(K_STOP);
    st(1'b0, 1'b1);
    i_keypad_term_model.set_ext(1'b0);
    i_keypad_term_model.press(K_SW);
    st(1'b1, 1'b0);
    i_keypad_term_model.press(K_RUN);
    st(1'b1, 1'b1);
    i_keypad_term_model.press(K_SW);
    st(1'b1, 1'b1);
    i_keypad_term_model.press(K_STOP);
    i_keypad_term_model.set_ext(1'b1);
    st(1'b1, 1'b0);
    i_keypad_term_model.press(K_SW);
    st(1'b0, 1'b0);
    i_keypad_term_model.rerun();
    st(1'b0, 1'b1);
    i_keypad_term_model.set_ext(1'b0);
    i_keypad_term_model.press(K_SW);
    wr(A_OPER_CTRL, 16'h0007);
    i_keypad_term_model.set_ext(1'b1);
    i_keypad_term_model.press(K_SW);
    st(1'b0, 1'b1);
    i_keypad_term_model.set_ext(1'b0);
    i_keypad_term_model.press(K_SW);
    wr(A_OPER_CTRL, 16'h0006);
    i_keypad_term_model.press(K_SW);
    st(1'b1, 1'b0);
    rchk("status", A_STATUS, 16'h0001);
    clk_en <= 1'b0;
    wr(A_FREQ_UNIT, 16'h0001);
    clk_en <= 1'b1;
    #1;
    chk("frozen", {15'h0, disp_unit_rpm}, 16'h0000);
    vector_mode <= 1'b1;
    arst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("unit", {15'h0, disp_unit_rpm}, 16'h0001);
    end_sim();
  end
endmodule : operator_panel_test
